// ---- core/time_of_day_converter.sv ----
// sequential conversion of civil seconds since 1970 into calendar fields
module time_of_day_converter
	import timecode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [31:0] seconds,
	output logic busy,
	output logic done,
	output logic [5:0] second,
	output logic [5:0] minute,
	output logic [4:0] hour,
	output logic [4:0] day,
	output logic [2:0] weekday,
	output logic [3:0] month,
	output logic [6:0] year
);
	typedef enum logic [2:0] {CV_IDLE, CV_DAYS, CV_HOURS, CV_MINUTES, CV_WEEK, CV_YEARS,
		CV_MONTHS} conv_state_t;

	conv_state_t state;
	logic [31:0] rest;
	logic [15:0] days;
	logic [15:0] week_rest;
	logic [11:0] year_full;
	logic [3:0] month_run;
	wire leap_year = (year_full[1:0] == 2'h0);
	wire [15:0] year_len = leap_year ? DAYS_PER_LEAP_YEAR : DAYS_PER_YEAR;
	wire [15:0] month_len = month_days(month_run, leap_year);

	assign busy = (state != CV_IDLE);

	// subtraction loops: slow but tiny, well under a millisecond at worst
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state <= CV_IDLE;
			done <= 1'b0;
			rest <= 32'h0;
			days <= 16'h0;
			week_rest <= 16'h0;
			year_full <= EPOCH_YEAR;
			month_run <= 4'h1;
			second <= 6'h0;
			minute <= 6'h0;
			hour <= 5'h0;
			day <= 5'h1;
			weekday <= 3'h1;
			month <= 4'h1;
			year <= 7'h0;
		end
		else
		begin
			done <= 1'b0;
			case (state)
				CV_IDLE:
					if (start)
					begin
						rest <= seconds;
						days <= 16'h0;
						year_full <= EPOCH_YEAR;
						month_run <= 4'h1;
						hour <= 5'h0;
						minute <= 6'h0;
						state <= CV_DAYS;
					end
				CV_DAYS:
					if (rest >= SECONDS_PER_DAY)
					begin
						rest <= rest - SECONDS_PER_DAY;
						days <= days + 16'd1;
					end
					else
					begin
						week_rest <= days + EPOCH_WEEKDAY_BIAS;
						state <= CV_HOURS;
					end
				CV_HOURS:
					if (rest >= SECONDS_PER_HOUR)
					begin
						rest <= rest - SECONDS_PER_HOUR;
						hour <= hour + 5'd1;
					end
					else
						state <= CV_MINUTES;
				CV_MINUTES:
					if (rest >= SECONDS_PER_MINUTE)
					begin
						rest <= rest - SECONDS_PER_MINUTE;
						minute <= minute + 6'd1;
					end
					else
					begin
						second <= rest[5:0];
						state <= CV_WEEK;
					end
				CV_WEEK:
					if (week_rest >= DAYS_PER_WEEK)
						week_rest <= week_rest - DAYS_PER_WEEK;
					else
					begin
						weekday <= week_rest[2:0] + 3'd1;
						state <= CV_YEARS;
					end
				CV_YEARS:
					if (days >= year_len)
					begin
						days <= days - year_len;
						year_full <= year_full + 12'd1;
					end
					else
						state <= CV_MONTHS;
				CV_MONTHS:
					if (days >= month_len)
					begin
						days <= days - month_len;
						month_run <= month_run + 4'd1;
					end
					else
					begin
						day <= days[4:0] + 5'd1;
						month <= month_run;
						year <= 7'(year_full % CENTURY);
						done <= 1'b1;
						state <= CV_IDLE;
					end
				default:
					state <= CV_IDLE;
			endcase
		end
	end
endmodule

// ---- core/timecode_pkg.sv ----
// shared constants and helpers of the pulse-width time code encoder
package timecode_pkg;
	// register offsets, bit positions and reset values
	localparam logic [31:0] CONTROL_OFFSET = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
	localparam logic [31:0] VERSION_OFFSET = 32'h0000_000c;
	localparam logic [31:0] CORRECTION_OFFSET = 32'h0000_0010;
	localparam int ENABLE_BIT = 0;
	localparam int ERROR_BIT = 0;
	localparam int OFFSET_SIGN_BIT = 31;
	localparam int OFFSET_SECONDS_W = 31;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] CORRECTION_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// symbol timing, printed in milliseconds, applied in nanoseconds
	localparam int SYMBOL_PERIOD_MS = 1000;
	localparam int ZERO_PULSE_MS = 100;
	localparam int ONE_PULSE_MS = 200;
	localparam int NS_PER_MS = 1000000;
	localparam logic [31:0] NS_PER_SECOND = 32'(SYMBOL_PERIOD_MS * NS_PER_MS);
	localparam logic [31:0] ZERO_PULSE_NS = 32'(ZERO_PULSE_MS * NS_PER_MS);
	localparam logic [31:0] ONE_PULSE_NS = 32'(ONE_PULSE_MS * NS_PER_MS);
	localparam int CLK_PERIOD_NS = 4;
	localparam int PIPE_STAGES = 2;

	// frame layout, bit index within the minute
	localparam int FRAME_LEN = 60;
	localparam int WEATHER_LSB = 1;
	localparam int WEATHER_W = 14;
	localparam int CALL_BIT = 15;
	localparam int DST_CHANGE_BIT = 16;
	localparam int DST_A_BIT = 17;
	localparam int DST_B_BIT = 18;
	localparam int LEAP_BIT = 19;
	localparam int START_BIT = 20;
	localparam int MINUTE_LSB = 21;
	localparam int MINUTE_PAR_BIT = 28;
	localparam int HOUR_LSB = 29;
	localparam int HOUR_PAR_BIT = 35;
	localparam int DAY_LSB = 36;
	localparam int WEEKDAY_LSB = 42;
	localparam int MONTH_LSB = 45;
	localparam int YEAR_LSB = 50;
	localparam int DATE_PAR_BIT = 58;
	localparam logic [5:0] MARKER_INDEX = 6'd59;
	localparam logic [5:0] FIRST_INDEX = 6'd0;

	// calendar conversion
	localparam logic [31:0] SECONDS_PER_DAY = 32'd86400;
	localparam logic [31:0] SECONDS_PER_HOUR = 32'd3600;
	localparam logic [31:0] SECONDS_PER_MINUTE = 32'd60;
	localparam logic [31:0] LOOKAHEAD_SECONDS = 32'd61;
	localparam logic [15:0] DAYS_PER_WEEK = 16'd7;
	localparam logic [15:0] DAYS_PER_YEAR = 16'd365;
	localparam logic [15:0] DAYS_PER_LEAP_YEAR = 16'd366;
	localparam logic [11:0] EPOCH_YEAR = 12'd1970;
	localparam logic [11:0] CENTURY = 12'd100;
	localparam logic [15:0] EPOCH_WEEKDAY_BIAS = 16'd3;

	function automatic logic [7:0] to_bcd(input logic [6:0] value);
		return {4'(value / 7'd10), 4'(value % 7'd10)};
	endfunction

	function automatic logic [15:0] month_days(input logic [3:0] month, input logic leap);
		case (month)
			4'h2: return leap ? 16'd29 : 16'd28;
			4'h4, 4'h6, 4'h9, 4'hb: return 16'd30;
			default: return 16'd31;
		endcase
	endfunction
endpackage

// ---- core/timecode_pwm_dc_level_shift_output_encoder.sv ----
// minute frame time code encoder with register slave and jump supervision
module timecode_pwm_dc_level_shift_output_encoder
	import timecode_pkg::*;
#(
	parameter bit STATIC_CONFIG = 1'b0,
	parameter int OUTPUT_DELAY_NS = 0,
	parameter logic [7:0] VERSION_MAJOR = 8'h01,
	parameter logic [7:0] VERSION_MINOR = 8'h00,
	parameter logic [15:0] VERSION_BUILD = 16'h0000
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] ref_seconds,
	input wire logic [31:0] ref_nanoseconds,
	input wire logic static_enable,
	input wire logic static_offset_sign,
	input wire logic [30:0] static_offset_seconds,
	input wire logic [13:0] weather_info,
	input wire logic dst_change_announce,
	input wire logic dst_state_a,
	input wire logic dst_state_b,
	input wire logic leap_announce,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic dc_level_shift_output,
	output logic error_status
);
	// two register stages sit between reference and pin, so they are advanced as well
	localparam logic [32:0] DELAY_TOTAL_NS = 33'(OUTPUT_DELAY_NS + PIPE_STAGES * CLK_PERIOD_NS);

	if (OUTPUT_DELAY_NS < 0 || DELAY_TOTAL_NS >= {1'b0, NS_PER_SECOND})
		$error("output delay must lie within one second");

	logic [31:0] control;
	logic [31:0] correction;
	logic sticky_error;

	// register slave: address and data taken together, no byte lanes
	wire write_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire read_take = s_axi_arvalid && !s_axi_rvalid;
	wire wr_control = (s_axi_awaddr == CONTROL_OFFSET);
	wire wr_status = (s_axi_awaddr == STATUS_OFFSET);
	wire wr_correction = (s_axi_awaddr == CORRECTION_OFFSET);
	wire wr_mapped = wr_control || wr_status || wr_correction
		|| (s_axi_awaddr == VERSION_OFFSET);
	wire rd_control = (s_axi_araddr == CONTROL_OFFSET);
	wire rd_status = (s_axi_araddr == STATUS_OFFSET);
	wire rd_version = (s_axi_araddr == VERSION_OFFSET);
	wire rd_correction = (s_axi_araddr == CORRECTION_OFFSET);
	wire rd_mapped = rd_control || rd_status || rd_version || rd_correction;
	wire [31:0] version_word = {VERSION_MAJOR, VERSION_MINOR, VERSION_BUILD};
	wire [31:0] status_word = {31'h0, sticky_error};
	wire [31:0] read_word = rd_control ? {31'h0, control[ENABLE_BIT]}
		: rd_status ? status_word
		: rd_version ? version_word
		: rd_correction ? correction
		: 32'h0;
	wire error_clear = write_take && wr_status && s_axi_wdata[ERROR_BIT];

	assign s_axi_awready = write_take;
	assign s_axi_wready = write_take;
	assign s_axi_arready = read_take;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			control <= CONTROL_RESET;
			correction <= CORRECTION_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (write_take && wr_control)
				control <= s_axi_wdata;
			if (write_take && wr_correction)
				correction <= s_axi_wdata;
			if (write_take)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (read_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// configuration source: registers or static inputs
	wire enable = STATIC_CONFIG ? static_enable : control[ENABLE_BIT];
	wire offset_sign = STATIC_CONFIG ? static_offset_sign : correction[OFFSET_SIGN_BIT];
	wire [30:0] offset_seconds = STATIC_CONFIG ? static_offset_seconds
		: correction[OFFSET_SECONDS_W-1:0];

	// time jump supervision on the raw reference
	logic [31:0] prev_ref_sec;
	logic [31:0] prev_ref_ns;
	logic ref_seen;
	wire jump = ref_seen && enable
		&& (((ref_seconds == prev_ref_sec) && (ref_nanoseconds < prev_ref_ns))
		|| ((ref_seconds != prev_ref_sec) && (ref_seconds != prev_ref_sec + 32'd1)));

	// advance the reference by the compensation delay
	wire [32:0] ns_sum = {1'b0, ref_nanoseconds} + DELAY_TOTAL_NS;
	wire ns_wrap = (ns_sum >= {1'b0, NS_PER_SECOND});
	wire [31:0] adv_ns = ns_wrap ? 32'(ns_sum - {1'b0, NS_PER_SECOND}) : ns_sum[31:0];
	wire [31:0] adv_sec = ns_wrap ? ref_seconds + 32'd1 : ref_seconds;

	logic [31:0] sh_sec;
	logic [31:0] sh_ns;
	logic [31:0] prev_sh_sec;
	wire tick = (sh_sec != prev_sh_sec);
	// signed offset: sign set means the seconds are taken away
	wire [31:0] civil_sec = offset_sign ? sh_sec - {1'b0, offset_seconds}
		: sh_sec + {1'b0, offset_seconds};

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			prev_ref_sec <= 32'h0;
			prev_ref_ns <= 32'h0;
			ref_seen <= 1'b0;
			sh_sec <= 32'h0;
			sh_ns <= 32'h0;
			prev_sh_sec <= 32'h0;
		end
		else
		begin
			prev_ref_sec <= ref_seconds;
			prev_ref_ns <= ref_nanoseconds;
			ref_seen <= 1'b1;
			sh_sec <= adv_sec;
			sh_ns <= adv_ns;
			prev_sh_sec <= sh_sec;
		end
	end

	// converter works one second ahead, fields describe the next minute start
	logic conv_busy;
	logic conv_done;
	logic [5:0] cv_second;
	logic [5:0] cv_minute;
	logic [4:0] cv_hour;
	logic [4:0] cv_day;
	logic [2:0] cv_weekday;
	logic [3:0] cv_month;
	logic [6:0] cv_year;
	logic conv_ok;
	logic conv_discard;

	time_of_day_converter converter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(tick && !jump),
		.seconds(civil_sec + LOOKAHEAD_SECONDS),
		.busy(conv_busy),
		.done(conv_done),
		.second(cv_second),
		.minute(cv_minute),
		.hour(cv_hour),
		.day(cv_day),
		.weekday(cv_weekday),
		.month(cv_month),
		.year(cv_year)
	);

	wire [7:0] bcd_minute = to_bcd({1'b0, cv_minute});
	wire [7:0] bcd_hour = to_bcd({2'h0, cv_hour});
	wire [7:0] bcd_day = to_bcd({2'h0, cv_day});
	wire [7:0] bcd_month = to_bcd({3'h0, cv_month});
	wire [7:0] bcd_year = to_bcd(cv_year);
	wire [FRAME_LEN-1:0] frame_next;

	assign frame_next[0] = 1'b0;
	assign frame_next[WEATHER_LSB +: WEATHER_W] = weather_info;
	assign frame_next[CALL_BIT] = 1'b0;
	assign frame_next[DST_CHANGE_BIT] = dst_change_announce;
	assign frame_next[DST_A_BIT] = dst_state_a;
	assign frame_next[DST_B_BIT] = dst_state_b;
	assign frame_next[LEAP_BIT] = leap_announce;
	assign frame_next[START_BIT] = 1'b1;
	assign frame_next[MINUTE_LSB +: 7] = bcd_minute[6:0];
	assign frame_next[MINUTE_PAR_BIT] = ^bcd_minute[6:0];
	assign frame_next[HOUR_LSB +: 6] = bcd_hour[5:0];
	assign frame_next[HOUR_PAR_BIT] = ^bcd_hour[5:0];
	assign frame_next[DAY_LSB +: 6] = bcd_day[5:0];
	assign frame_next[WEEKDAY_LSB +: 3] = cv_weekday;
	assign frame_next[MONTH_LSB +: 5] = bcd_month[4:0];
	assign frame_next[YEAR_LSB +: 8] = bcd_year;
	assign frame_next[DATE_PAR_BIT] = ^{bcd_day[5:0], cv_weekday, bcd_month[4:0], bcd_year};
	assign frame_next[MARKER_INDEX] = 1'b0;

	// symbol sequencing; a new frame only starts on a minute boundary
	logic [FRAME_LEN-1:0] frame;
	logic frame_valid;
	logic [5:0] symbol_index;
	wire load_frame = tick && conv_ok && enable && (cv_second == FIRST_INDEX);
	wire next_valid = jump || !enable ? 1'b0
		: load_frame ? 1'b1
		: tick && !conv_ok ? 1'b0
		: frame_valid;
	wire [5:0] next_index = tick && conv_ok ? cv_second : symbol_index;
	wire next_bit = load_frame ? frame_next[next_index] : frame[next_index];
	wire [31:0] pulse_ns = next_bit ? ONE_PULSE_NS : ZERO_PULSE_NS;
	// reference nanoseconds are compared every clock, so widths follow corrections
	wire next_out = next_valid && (next_index != MARKER_INDEX)
		&& (sh_ns < pulse_ns);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			frame <= '0;
			frame_valid <= 1'b0;
			symbol_index <= FIRST_INDEX;
			conv_ok <= 1'b0;
			conv_discard <= 1'b0;
			dc_level_shift_output <= 1'b0;
		end
		else
		begin
			if (load_frame)
				frame <= frame_next;
			frame_valid <= next_valid;
			symbol_index <= next_index;
			dc_level_shift_output <= next_out;
			// a result started before a jump describes the wrong time
			if (jump || tick)
				conv_ok <= 1'b0;
			else if (conv_done && !conv_discard)
				conv_ok <= 1'b1;
			if (jump && conv_busy)
				conv_discard <= 1'b1;
			else if (conv_done)
				conv_discard <= 1'b0;
		end
	end

	// sticky error: a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			sticky_error <= 1'b0;
		else if (jump)
			sticky_error <= 1'b1;
		else if (error_clear)
			sticky_error <= 1'b0;
	end

	assign error_status = sticky_error;
endmodule

// ---- sim/dc_level_shift_output_receiver.sv ----
// receiver model on the level-shift line: counts pulses and decodes symbols by width
module dc_level_shift_output_receiver
#(
	parameter int ONE_MIN = 30
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic line,
	output logic [15:0] pulse_count,
	output logic [58:0] bits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic line_q;
	logic [15:0] width;
	// a rising edge starts a zero or one symbol; markers show no edge
	// widths from the midpoint up count as one; bit 0 of a frame ends up lowest
	always @(posedge sys_clk)
	begin
		line_q <= line;
		if (!rst_n)
		begin
			pulse_count <= 16'h0;
			width <= 16'h0;
			bits <= '0;
		end
		else
		begin
			if (line && !line_q)
				pulse_count <= pulse_count + 16'h1;
			width <= line ? width + 16'h1 : 16'h0;
			if (!line && line_q)
				bits <= {(width >= 16'(ONE_MIN)), bits[58:1]};
		end
	end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench: registers, decode errors, time jumps, idle output, one minute frame
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import timecode_pkg::*;
	localparam logic [31:0] VERSION_WORD = 32'h0205_0103;
	localparam logic [31:0] STEP_NS = 32'h004c_4b40;
	localparam int ONE_MIN = int'((ZERO_PULSE_NS + ONE_PULSE_NS) / 32'h2 / STEP_NS);
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	// six seconds before a civil minute rollover, early in the epoch so conversions stay short
	logic [31:0] elapsed_s = 32'h002c_1bd6;
	logic [31:0] ref_nanoseconds = 32'h0;
	logic [31:0] skew = 32'h0;
	wire logic [31:0] ref_seconds = elapsed_s - skew;
	logic [13:0] weather_info = 14'h2a5;
	logic dst_change_announce = 1'b0;
	logic dst_state_a = 1'b1;
	logic dst_state_b = 1'b0;
	logic leap_announce = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic dc_level_shift_output, error_status;
	logic [15:0] pulse_count;
	logic [58:0] rx_bits;
	int n_errors = 0;
	int n_tests = 0;

	timecode_pwm_dc_level_shift_output_encoder #(
		.VERSION_MAJOR(8'h02),
		.VERSION_MINOR(8'h05),
		.VERSION_BUILD(16'h0103)
	) dut (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.ref_seconds(ref_seconds), .ref_nanoseconds(ref_nanoseconds),
		.static_enable(1'b0), .static_offset_sign(1'b0), .static_offset_seconds(31'h0),
		.weather_info(weather_info), .dst_change_announce(dst_change_announce),
		.dst_state_a(dst_state_a), .dst_state_b(dst_state_b), .leap_announce(leap_announce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.dc_level_shift_output(dc_level_shift_output), .error_status(error_status)
	);

	dc_level_shift_output_receiver #(.ONE_MIN(ONE_MIN)) rx (.sys_clk(sys_clk), .rst_n(rst_n),
		.line(dc_level_shift_output), .pulse_count(pulse_count), .bits(rx_bits));

	always #2 sys_clk = ~sys_clk;

	// reference runs 5 ms a cycle, so a second is 200 cycles; skew steps make the jumps
	always @(negedge sys_clk)
	begin
		if (ref_nanoseconds >= NS_PER_SECOND - STEP_NS)
		begin
			ref_nanoseconds <= 32'h0;
			elapsed_s <= elapsed_s + 32'h1;
		end
		else
			ref_nanoseconds <= ref_nanoseconds + STEP_NS;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// response ready comes a cycle late so the hold of the answer is seen
	task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
		input logic [1:0] resp);
		int i;
		@(negedge sys_clk);
		s_axi_awaddr = addr;
		s_axi_wdata = data;
		s_axi_awvalid = 1'b1;
		s_axi_wvalid = 1'b1;
		i = 0;
		do @(posedge sys_clk); while (s_axi_awready !== 1'b1 && ++i < 50);
		@(negedge sys_clk);
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		check("bvalid", 32'h1, 32'(s_axi_bvalid));
		@(negedge sys_clk);
		check("bresp", 32'(resp), 32'(s_axi_bresp));
		s_axi_bready = 1'b1;
		@(negedge sys_clk);
		s_axi_bready = 1'b0;
	endtask

	task automatic axi_read(input logic [31:0] addr, input logic [31:0] data,
		input logic [1:0] resp);
		int i;
		@(negedge sys_clk);
		s_axi_araddr = addr;
		s_axi_arvalid = 1'b1;
		i = 0;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1 && ++i < 50);
		@(negedge sys_clk);
		s_axi_arvalid = 1'b0;
		check("rvalid", 32'h1, 32'(s_axi_rvalid));
		@(negedge sys_clk);
		check("rresp", 32'(resp), 32'(s_axi_rresp));
		check("rdata", data, s_axi_rdata);
		s_axi_rready = 1'b1;
		@(negedge sys_clk);
		s_axi_rready = 1'b0;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		logic [31:0] holes[4];
		int n;
		holes = '{32'h8, 32'h14, 32'h40, 32'hfffc};
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		axi_read(CONTROL_OFFSET, CONTROL_RESET, RESP_OKAY);
		axi_read(STATUS_OFFSET, 32'h0, RESP_OKAY);
		axi_read(CORRECTION_OFFSET, CORRECTION_RESET, RESP_OKAY);
		axi_read(VERSION_OFFSET, VERSION_WORD, RESP_OKAY);
		axi_write(VERSION_OFFSET, 32'hffff_ffff, RESP_OKAY);
		axi_read(VERSION_OFFSET, VERSION_WORD, RESP_OKAY);
		// correction loaded while disabled, as the leap procedure asks
		axi_write(CORRECTION_OFFSET, 32'h8000_0024, RESP_OKAY);
		axi_read(CORRECTION_OFFSET, 32'h8000_0024, RESP_OKAY);
		foreach (holes[k])
		begin
			axi_write(holes[k], 32'h1, RESP_DECERR);
			axi_read(holes[k], 32'h0, RESP_DECERR);
		end
		axi_write(CONTROL_OFFSET, 32'hffff_ffff, RESP_OKAY);
		axi_read(CONTROL_OFFSET, 32'h1, RESP_OKAY);
		dst_change_announce = 1'b1;
		leap_announce = 1'b1;
		repeat (200) @(negedge sys_clk);
		check("error_status", 32'h0, 32'(error_status));
		skew = 32'h5;
		repeat (4) @(negedge sys_clk);
		check("error_status", 32'h1, 32'(error_status));
		check("dc_level_shift_output", 32'h0, 32'(dc_level_shift_output));
		axi_read(STATUS_OFFSET, 32'h1, RESP_OKAY);
		axi_write(STATUS_OFFSET, 32'h0, RESP_OKAY);
		axi_read(STATUS_OFFSET, 32'h1, RESP_OKAY);
		axi_write(STATUS_OFFSET, 32'h1, RESP_OKAY);
		axi_read(STATUS_OFFSET, 32'h0, RESP_OKAY);
		axi_write(CONTROL_OFFSET, 32'h0, RESP_OKAY);
		skew = 32'h0;
		repeat (4) @(negedge sys_clk);
		axi_read(STATUS_OFFSET, 32'h0, RESP_OKAY);
		check("dc_level_shift_output", 32'h0, 32'(dc_level_shift_output));
		check("pulses", 32'h0, 32'(pulse_count));
		// frame sent from 10:58 civil carries 10:59 on the third of february 1970
		axi_write(CONTROL_OFFSET, 32'h1, RESP_OKAY);
		n = 0;
		while (dc_level_shift_output !== 1'b1 && n < 2000)
		begin
			@(negedge sys_clk);
			n++;
		end
		check("minute edge", 32'h002c_1bdc, ref_seconds);
		repeat (19) @(negedge sys_clk);
		check("zero width", 32'h1, 32'(dc_level_shift_output));
		@(negedge sys_clk);
		check("zero end", 32'h0, 32'(dc_level_shift_output));
		repeat (4019) @(negedge sys_clk);
		check("one width", 32'h1, 32'(dc_level_shift_output));
		@(negedge sys_clk);
		check("one end", 32'h0, 32'(dc_level_shift_output));
		repeat (7860) @(negedge sys_clk);
		check("marker", 32'h0, 32'(dc_level_shift_output));
		check("symbols", 32'h3b, 32'(pulse_count));
		check("frame low", 32'h0b3b_054a, rx_bits[31:0]);
		check("frame high", 32'h05c0_483a, 32'(rx_bits[58:32]));
		repeat (99) @(negedge sys_clk);
		check("frame end", 32'h0, 32'(dc_level_shift_output));
		@(negedge sys_clk);
		check("next minute", 32'h1, 32'(dc_level_shift_output));
		check("next edge", 32'h002c_1c18, ref_seconds);
		wrap_up();
	end

	// the sequence needs about thirteen thousand cycles
	initial
	begin
		#80000;
		n_errors++;
		wrap_up();
	end
endmodule

// ---- sim/timecode_monitor.sv ----
// assertion checker on the ports of the time code encoder
module timecode_monitor
	import timecode_pkg::*;
#(
	parameter logic [7:0] VERSION_MAJOR = 8'h01,
	parameter logic [7:0] VERSION_MINOR = 8'h00,
	parameter logic [15:0] VERSION_BUILD = 16'h0000
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dc_level_shift_output,
	input wire logic error_status
);
	logic [31:0] hi_len;
	wire logic wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire logic rd_take = s_axi_arvalid && !s_axi_rvalid;
	wire logic wr_mapped = s_axi_awaddr inside {CONTROL_OFFSET, STATUS_OFFSET, VERSION_OFFSET,
		CORRECTION_OFFSET};
	wire logic rd_mapped = s_axi_araddr inside {CONTROL_OFFSET, STATUS_OFFSET, VERSION_OFFSET,
		CORRECTION_OFFSET};
	wire logic err_clear = wr_take && s_axi_awaddr == STATUS_OFFSET && s_axi_wdata[ERROR_BIT];
	// the longest legal pulse is a one symbol, counted in clocks
	always_ff @(posedge sys_clk)
		hi_len <= (!rst_n || !dc_level_shift_output) ? 32'h0 : hi_len + 32'h1;
	default clocking dflt @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_write_accept: assert property (
		wr_take |-> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
		else $error("write not answered one cycle after acceptance");
	a_read_accept: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered one cycle after acceptance");
	a_write_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response changed before rready");
	a_read_decerr: assert property (
		rd_take && !rd_mapped |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not answered with decode error");
	a_write_decerr: assert property (wr_take && !wr_mapped |=> s_axi_bresp == RESP_DECERR)
		else $error("unmapped write not answered with decode error");
	a_read_okay: assert property (rd_take && rd_mapped |=> s_axi_rresp == RESP_OKAY)
		else $error("mapped read not answered okay");
	a_version_word: assert property (
		rd_take && s_axi_araddr == VERSION_OFFSET
		|=> s_axi_rdata == {VERSION_MAJOR, VERSION_MINOR, VERSION_BUILD})
		else $error("version word wrong");
	a_error_sticky: assert property (error_status && !err_clear |=> error_status)
		else $error("error flag dropped without a clearing write");
	a_pulse_width: assert property (hi_len <= ONE_PULSE_NS / CLK_PERIOD_NS)
		else $error("output pulse longer than a one symbol");
endmodule

bind timecode_pwm_dc_level_shift_output_encoder timecode_monitor #(
	.VERSION_MAJOR(VERSION_MAJOR),
	.VERSION_MINOR(VERSION_MINOR),
	.VERSION_BUILD(VERSION_BUILD)
) monitor (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.dc_level_shift_output(dc_level_shift_output),
	.error_status(error_status)
);
